// ### hw/lvd_pkg.sv
// package for the supply drop detector and ram data status block
// Function
// [R01] compare supply, raise below and above events
// [R02] enable bit 7 gates detection
// [R03] mode bit 1: events or internal reset
// [R04] flag bit 0 shows below, read only
// [R05] software trusts flag only enabled event mode
// [R06] detector reset sets cause bit 0
// [R07] control and level registers clear on reset
// [R08] control writes only through protected sequence
// [R09] software writes zeros to control bits 6..2
// [R10] enable plus reset mode locks level register
// [R11] software writes zeros to level bits 7..1
// [R12] level bit 0 selects comparator threshold
// [R13] software waits settling time before reading flag
// [R14] detection keeps working in stop mode
// [R15] ram flag bit 0 set after retention drop
// [R16] ram status survives every reset
// [R17] ram status writes only through protected sequence
// [R18] emulation register acts only in emulation mode
// [R19] force bit sets ram flag by hardware
// [R20] force bit never clears itself
// [R21] force bit blocks clearing the ram flag
// [R22] ram flag set at power up, software clears
// [R23] reset mode locks control and level registers; the code locks them only while enable bit 7 is also set
// [R24] internal reset held while supply stays low
// [R25] synchronise comparator outputs before use
// [R26] rising edge below event, falling edge above
package lvd_pkg;

    localparam int LVD_DAT_W = 32;
    localparam int LVD_ADR_W = 32;
    localparam int LVD_DEC_W = 10;
    localparam int LVD_SEL_W = 4;

    // register indices; byte address is four times the index
    localparam logic [31:0] LVD_LEVEL_IDX = 32'h0ffff891;
    localparam logic [31:0] LVD_CTRL_IDX = 32'hfffff890;
    localparam logic [31:0] LVD_RAM_DATA_STATUS_IDX = 32'hfffff892;
    localparam logic [31:0] LVD_EMU_IDX = 32'hfffff9fe;
    localparam logic [31:0] LVD_CAUSE_IDX = 32'h000000f0;
    localparam logic [31:0] LVD_PROT_IDX = 32'h000000fc;

    localparam int LVD_EN_BIT = 7;
    localparam int LVD_MODE_BIT = 1;
    localparam int LVD_FLAG_BIT = 0;
    localparam int LVD_LEVEL_BIT = 0;
    localparam int LVD_RAM_INVALID_FLAG_ALT_BIT = 0;
    localparam int LVD_FORCE_BIT = 0;
    localparam int LVD_CAUSE_BIT = 0;
    localparam int LVD_ARM_BIT = 0;

    localparam logic [7:0] LVD_CTRL_RST = 8'h00;
    localparam logic [7:0] LVD_LEVEL_RST = 8'h00;
    localparam logic [7:0] LVD_PROT_KEY_DEF = 8'ha5;
    localparam int LVD_SYNC_STAGES = 2;

    typedef struct packed {
        logic detect_enable;
        logic [4:0] zero;
        logic reset_not_event_mode;
        logic low_supply_flag;
    } lvd_ctrl_t;

    typedef struct packed {
        logic supply_below_event;
        logic supply_above_event;
        logic supply_drop_reset;
    } lvd_evt_t;

    typedef enum {
        LVD_WB_IDLE,
        LVD_WB_ACK
    } lvd_wb_state_t;

    function automatic logic lvd_hit(input logic [LVD_ADR_W-1:0] adr,
                                     input logic [31:0] idx);
        lvd_hit = (adr[LVD_DEC_W+1:2] == idx[LVD_DEC_W-1:0]);
    endfunction

endpackage

// ### hw/lvd_top.sv
// supply drop detector control, reset cause and ram data status
`timescale 1ns/1ns
module lvd_top #(
    parameter logic [7:0] PROT_KEY = lvd_pkg::LVD_PROT_KEY_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pwr_on_i,
    input wire logic emu_mode_i,
    input wire logic cmp_below_i,
    input wire logic ram_below_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lvd_pkg::LVD_ADR_W-1:0] wb_adr_i,
    input wire logic [lvd_pkg::LVD_SEL_W-1:0] wb_sel_i,
    input wire logic [lvd_pkg::LVD_DAT_W-1:0] wb_dat_i,
    output logic [lvd_pkg::LVD_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic detect_enable_o,
    output logic threshold_choice_o,
    output logic ram_invalid_flag_o,
    output lvd_pkg::lvd_evt_t events_o
);

    lvd_pkg::lvd_wb_state_t state_reg;
    lvd_pkg::lvd_wb_state_t state_next;
    lvd_pkg::lvd_ctrl_t ctrl_reg;
    lvd_pkg::lvd_evt_t evt_reg;
    logic level_reg;
    logic ram_flag_reg;
    logic force_reg;
    logic cause_reg;
    logic arm_reg;
    logic ack_reg;
    logic [lvd_pkg::LVD_DAT_W-1:0] dat_reg;
    logic [lvd_pkg::LVD_SYNC_STAGES-1:0] cmp_sync_reg;
    logic [lvd_pkg::LVD_SYNC_STAGES-1:0] ram_sync_reg;
    logic below_prev_reg;

    // bus request decode
    wire req = wb_cyc_i && wb_stb_i && (state_reg == lvd_pkg::LVD_WB_IDLE);
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire hit_level = lvd_pkg::lvd_hit(wb_adr_i, lvd_pkg::LVD_LEVEL_IDX);
    wire hit_ctrl = lvd_pkg::lvd_hit(wb_adr_i, lvd_pkg::LVD_CTRL_IDX);
    wire hit_ram_data_status = lvd_pkg::lvd_hit(wb_adr_i, lvd_pkg::LVD_RAM_DATA_STATUS_IDX);
    wire hit_emu = lvd_pkg::lvd_hit(wb_adr_i, lvd_pkg::LVD_EMU_IDX);
    wire hit_cause = lvd_pkg::lvd_hit(wb_adr_i, lvd_pkg::LVD_CAUSE_IDX);
    wire hit_prot = lvd_pkg::lvd_hit(wb_adr_i, lvd_pkg::LVD_PROT_IDX);

    // synchronised comparator results
    wire below_s = cmp_sync_reg[lvd_pkg::LVD_SYNC_STAGES-1]; // [R25]
    wire ram_low_s = ram_sync_reg[lvd_pkg::LVD_SYNC_STAGES-1]; // [R25]

    wire en = ctrl_reg.detect_enable; // [R02]
    wire rst_mode = ctrl_reg.reset_not_event_mode; // [R03]
    // once armed for reset, config stays frozen until a foreign reset
    wire locked = en && rst_mode; // [R10] [R23]
    wire low_flag = en && below_s; // [R04]
    wire fall_edge = below_s && !below_prev_reg; // [R26]
    wire rise_edge = !below_s && below_prev_reg; // [R26]
    wire evt_mode = en && !rst_mode; // [R03]
    wire drop_rst = locked && below_s; // [R24]
    // no stop-mode input: nothing here ever gates on power state
    wire keep_running = 1'b1; // [R14]

    // protected sequence: a key write arms the very next write
    wire prot_ok = arm_reg && !hit_prot; // [R08] [R17]
    wire ctrl_wr = wr && hit_ctrl && prot_ok && !locked; // [R08] [R23]
    wire level_wr = wr && hit_level && !locked; // [R10]
    wire ram_data_status_wr = wr && hit_ram_data_status && prot_ok; // [R17]
    wire emu_wr = wr && hit_emu && emu_mode_i; // [R18]
    wire force_on = force_reg && emu_mode_i; // [R18]
    wire ram_set = ram_low_s || force_on || pwr_on_i; // [R15] [R19] [R22]
    wire ram_wval = wbyte[lvd_pkg::LVD_RAM_INVALID_FLAG_ALT_BIT];
    // set wins over a software clear in the same cycle
    wire ram_next = ram_set || (ram_data_status_wr ? ram_wval : ram_flag_reg); // [R21]
    wire cause_clr = wr && hit_cause && !wbyte[lvd_pkg::LVD_CAUSE_BIT];
    wire cause_next = drop_rst || (cause_reg && !cause_clr); // [R06]

    lvd_pkg::lvd_ctrl_t ctrl_rd;
    assign ctrl_rd = '{detect_enable: en, zero: 5'h00,
                       reset_not_event_mode: rst_mode,
                       low_supply_flag: low_flag}; // [R04]

    wire [7:0] rd_byte =
        hit_ctrl ? ctrl_rd :
        hit_level ? {7'h00, level_reg} :
        hit_ram_data_status ? {7'h00, ram_flag_reg} :
        hit_emu ? {7'h00, force_reg && emu_mode_i} :
        hit_cause ? {7'h00, cause_reg} :
        hit_prot ? {7'h00, arm_reg} : 8'h00;

    always_comb begin
        case (state_reg)
            lvd_pkg::LVD_WB_IDLE: begin
                state_next = req ? lvd_pkg::LVD_WB_ACK : lvd_pkg::LVD_WB_IDLE;
            end
            lvd_pkg::LVD_WB_ACK: begin
                state_next = lvd_pkg::LVD_WB_IDLE;
            end
            default: begin
                state_next = lvd_pkg::LVD_WB_IDLE;
            end
        endcase
    end

    // bus slave: one-cycle ack, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= lvd_pkg::LVD_WB_IDLE;
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            ack_reg <= req;
            if (req) begin
                dat_reg <= {24'h000000, rd_byte};
            end
        end
    end

    // synchronisers and edge history run regardless of reset mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_sync_reg <= '0;
            ram_sync_reg <= '0;
            below_prev_reg <= 1'b0;
        end else if (keep_running) begin // [R14]
            cmp_sync_reg <= {cmp_sync_reg[0], cmp_below_i}; // [R25]
            ram_sync_reg <= {ram_sync_reg[0], ram_below_i}; // [R25]
            below_prev_reg <= below_s;
        end
    end

    // rst_i is any reset other than our own drop reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= lvd_pkg::LVD_CTRL_RST; // [R07]
            level_reg <= lvd_pkg::LVD_LEVEL_RST[0]; // [R07]
            arm_reg <= 1'b0;
            cause_reg <= 1'b0;
            evt_reg <= '0;
        end else begin
            if (ctrl_wr) begin
                ctrl_reg.detect_enable <= wbyte[lvd_pkg::LVD_EN_BIT];
                ctrl_reg.reset_not_event_mode <= wbyte[lvd_pkg::LVD_MODE_BIT];
            end
            ctrl_reg.zero <= 5'h00;
            ctrl_reg.low_supply_flag <= 1'b0;
            if (level_wr) begin
                level_reg <= wbyte[lvd_pkg::LVD_LEVEL_BIT]; // [R12]
            end
            if (wr) begin
                arm_reg <= hit_prot && (wbyte == PROT_KEY);
            end
            cause_reg <= cause_next; // [R06]
            evt_reg.supply_below_event <= evt_mode && fall_edge; // [R01]
            evt_reg.supply_above_event <= evt_mode && rise_edge; // [R01]
            evt_reg.supply_drop_reset <= drop_rst; // [R24]
        end
    end

    // ram status and force bit only see power-on, never rst_i
    always_ff @(posedge clk_i) begin
        ram_flag_reg <= ram_next; // [R16] [R22]
        if (pwr_on_i) begin
            force_reg <= 1'b0;
        end else if (emu_wr) begin
            force_reg <= wbyte[lvd_pkg::LVD_FORCE_BIT]; // [R20]
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign detect_enable_o = ctrl_reg.detect_enable;
    assign threshold_choice_o = level_reg; // [R12]
    assign ram_invalid_flag_o = ram_flag_reg;
    assign events_o = evt_reg;

endmodule // lvd_top

// ### testbench/lvd_top_assertions.sv
// assertion checker for the supply drop detector block
`timescale 1ns/1ns
module lvd_top_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmp_below_i,
    input wire logic ram_below_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic detect_enable_o,
    input wire logic threshold_choice_o,
    input wire logic ram_invalid_flag_o,
    input wire lvd_pkg::lvd_evt_t events_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
    AST_EN: assert property (
        $changed(detect_enable_o) && !$past(rst_i) |-> wb_ack_o)
        else $error("enable changed without a bus write");
    AST_LVL: assert property (
        $changed(threshold_choice_o) && !$past(rst_i) |-> wb_ack_o)
        else $error("level changed without a bus write");
    // the pulse reflects the pin three edges back, through two stages
    AST_BELOW: assert property (
        events_o.supply_below_event |-> $past(detect_enable_o)
        && $past(cmp_below_i, 3) ##1 !events_o.supply_below_event)
        else $error("bad below event");
    AST_ABOVE: assert property (
        events_o.supply_above_event |-> $past(detect_enable_o)
        && !$past(cmp_below_i, 3) ##1 !events_o.supply_above_event)
        else $error("bad above event");
    AST_MODE: assert property (
        events_o.supply_drop_reset |-> detect_enable_o && !(events_o
        .supply_below_event || events_o.supply_above_event))
        else $error("reset and event together");
    AST_DROP: assert property (
        events_o.supply_drop_reset && cmp_below_i && $past(cmp_below_i)
        && $past(cmp_below_i, 2) |=> events_o.supply_drop_reset)
        else $error("drop reset released while low");
    AST_RAMSET: assert property (
        ram_below_i [*4] |=> ram_invalid_flag_o)
        else $error("ram flag not set");
    AST_RAMCLR: assert property (
        $fell(ram_invalid_flag_o) |-> wb_ack_o)
        else $error("ram flag cleared without a write");
endmodule // lvd_top_chk

bind lvd_top lvd_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .cmp_below_i(cmp_below_i), .ram_below_i(ram_below_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .detect_enable_o(detect_enable_o),
    .threshold_choice_o(threshold_choice_o),
    .ram_invalid_flag_o(ram_invalid_flag_o), .events_o(events_o));

// ### testbench/lvd_top_bench.sv
// self-checking bench for the supply drop detector block
`timescale 1ns/1ns
module lvd_top_bench;
    logic clk_i = 1'b0, rst_i = 1'b1, pwr_on_i = 1'b1, emu_mode_i = 1'b0;
    logic cmp_below_i = 1'b0, ram_below_i = 1'b0, wb_ack_o;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic [3:0] wb_sel_i = 4'h1;
    logic detect_enable_o, threshold_choice_o, ram_invalid_flag_o;
    lvd_pkg::lvd_evt_t events_o;
    int error_cnt = 0, compares = 0, nb = 0, na = 0, eb = 0, ea = 0;
    always #2 clk_i = ~clk_i;
    lvd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .pwr_on_i(pwr_on_i),
        .emu_mode_i(emu_mode_i), .cmp_below_i(cmp_below_i),
        .ram_below_i(ram_below_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .detect_enable_o(detect_enable_o),
        .threshold_choice_o(threshold_choice_o),
        .ram_invalid_flag_o(ram_invalid_flag_o), .events_o(events_o));
    // event pulses last one cycle, so count them on every edge
    always @(posedge clk_i) begin
        nb += (events_o.supply_below_event === 1'b1);
        na += (events_o.supply_above_event === 1'b1);
    end
    task automatic chk(input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic we, input logic [31:0] a, d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // only the watchdog ends a wait; ack follows the taking edge
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk(n, 2);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [31:0] a, e);
        wb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // key first: the next write disarms again unless it is another key write
    task automatic pw(input logic [31:0] a, d);
        wb(1'b1, 32'h3f0, 32'ha5);
        wb(1'b1, a, d);
    endtask
    task automatic test_done;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        test_done;
    end
    initial begin
        rdat = $urandom(32'h8b29a050);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        pwr_on_i <= 1'b0;
        @(posedge clk_i);
        chk(ram_invalid_flag_o, 1);
        rd(32'h240, 0);
        rd(32'h244, 0);
        wb(1'b1, 32'h100, $urandom);
        rd(32'h100, 0);
        wb(1'b1, 32'h240, 32'h80);
        rd(32'h240, 0);
        wb(1'b1, 32'h244, 1);
        chk(threshold_choice_o, 1);
        pw(32'h240, 32'h80);
        chk(detect_enable_o, 1);
        cmp_below_i <= 1'b1;
        eb++;
        repeat (8) @(posedge clk_i);
        chk(nb, eb);
        rd(32'h240, 32'h81);
        cmp_below_i <= 1'b0;
        ea++;
        repeat (8) @(posedge clk_i);
        chk(na, ea);
        rd(32'h240, 32'h80);
        pw(32'h240, 32'h82);
        cmp_below_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(events_o.supply_drop_reset, 1);
        chk(nb, eb);
        rd(32'h3c0, 1);
        wb(1'b1, 32'h3c0, 0);
        rd(32'h3c0, 1);
        wb(1'b1, 32'h244, 0);
        chk(threshold_choice_o, 1);
        pw(32'h240, 0);
        rd(32'h240, 32'h83);
        // comparator stays low through reset: flag must now read 0
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(32'h3c0, 0);
        rd(32'h240, 0);
        chk(threshold_choice_o, 0);
        chk(events_o.supply_drop_reset, 0);
        chk(ram_invalid_flag_o, 1);
        wb(1'b1, 32'h248, 0);
        chk(ram_invalid_flag_o, 1);
        wb(1'b1, 32'h3f0, 32'ha5);
        rd(32'h3f0, 1);
        pw(32'h248, 0);
        chk(ram_invalid_flag_o, 0);
        ram_below_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        ram_below_i <= 1'b0;
        @(posedge clk_i);
        chk(ram_invalid_flag_o, 1);
        pw(32'h248, 0);
        wb(1'b1, 32'h7f8, 1);
        chk(ram_invalid_flag_o, 0);
        emu_mode_i <= 1'b1;
        wb(1'b1, 32'h7f8, 1);
        repeat (4) @(posedge clk_i);
        chk(ram_invalid_flag_o, 1);
        pw(32'h248, 0);
        chk(ram_invalid_flag_o, 1);
        rd(32'h7f8, 1);
        wb(1'b1, 32'h7f8, 0);
        pw(32'h248, 0);
        chk(ram_invalid_flag_o, 0);
        test_done;
    end
endmodule // lvd_top_bench
